// [ocpf_ctrl.sv]
// Over-current protection controller with APB register file and interrupt.
// Assumes sense_over_thresh and load_above_release come from synchronous comparators.
`timescale 1ns/1ns

// Contract
// - Protection is entered only after the sense differential stays above threshold for the whole detection delay.
// - On entry to protection the discharge gate is driven off with no host action.
// - In protection a load monitor state sources the load test current from the charge gate pin.
// - Protection ends only after the load resistance stays above the release level for the whole release delay.
// - On release the discharge FET turns on again unless software changed its control bit meanwhile.
// - A rising sense differential starts the detection timer while operation stays normal.
// - At detection timer expiry protection starts only if the sense differential is still high.
// - Control bit writes are accepted in protection but both gate pins hold until it ends.
// - Detection and release delays both come from one timing capacitor, about 10 ms typical.
// - A two-bit configuration field written by the host selects the applied threshold level.
// - The regulator stays enabled throughout protection.
// - In normal operation below threshold the discharge FET follows its control bit, which resets to on.
module ocpf_ctrl
  import ocpf_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES = OC_DELAY_CYC
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Analog comparators
  input  wire logic              sense_over_thresh,
  input  wire logic              load_above_release,
  // Pins and analog controls
  output logic                   discharge_gate_pin,
  output logic                   charge_gate_load_monitor_pin,
  output logic                   load_test_current_en,
  output logic                   oc_threshold_sel_hi,
  output logic                   oc_threshold_sel_lo,
  output logic                   regulator_en,
  // Interrupt
  output logic                   irq
);

  localparam int unsigned CNT_W = $clog2(DELAY_CYCLES + 1);
  ocpf_state_t       state_r;
  ocpf_state_t       state_nxt;
  logic [CTRL_W-1:0] ctrl_r;
  logic [CFG_W-1:0]  cfg_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic              dsg_changed_r;
  logic [DATA_W-1:0] prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic              dsg_pin_r;
  logic              chg_pin_r;
  logic              lmon_r;
  logic              sel_hi_r;
  logic              sel_lo_r;
  logic              reg_en_r;
  logic              irq_r;
  logic              tmr_start;
  logic              tmr_abort;
  logic              tmr_running;
  logic              tmr_done;
  logic              wr_en;
  logic              setup;
  logic              mapped;
  logic              in_prot;
  logic              prot_nxt;
  logic              ev_enter;
  logic              ev_exit;
  logic              ev_abort;
  logic [IRQ_W-1:0]  ev_vec;
  logic [DATA_W-1:0] rd_mux;

  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pready_r && pwrite && !pslverr_r;
  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_CONFIG) || (paddr == ADDR_STATUS) ||
                  (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK);

  assign in_prot  = (state_r == OCPF_LOADMON) || (state_r == OCPF_RELEASE);
  assign prot_nxt = (state_nxt == OCPF_LOADMON) || (state_nxt == OCPF_RELEASE);

  // Protection state machine
  always_comb begin
    state_nxt = state_r;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    ev_enter  = 1'b0;
    ev_exit   = 1'b0;
    ev_abort  = 1'b0;
    unique case (state_r)
      OCPF_NORMAL: begin
        if (sense_over_thresh) begin
          state_nxt = OCPF_DETECT;
          tmr_start = 1'b1;
        end
      end
      OCPF_DETECT: begin
        if (tmr_done) begin
          if (sense_over_thresh) begin
            state_nxt = OCPF_LOADMON;
            ev_enter  = 1'b1;
          end else begin
            state_nxt = OCPF_NORMAL;
            ev_abort  = 1'b1;
          end
        end else if (!sense_over_thresh) begin
          state_nxt = OCPF_NORMAL;
          tmr_abort = 1'b1;
          ev_abort  = 1'b1;
        end
      end
      OCPF_LOADMON: begin
        if (load_above_release) begin
          state_nxt = OCPF_RELEASE;
          tmr_start = 1'b1;
        end
      end
      OCPF_RELEASE: begin
        if (tmr_done) begin
          if (load_above_release && !sense_over_thresh) begin
            state_nxt = OCPF_NORMAL;
            ev_exit   = 1'b1;
          end else begin
            state_nxt = OCPF_LOADMON;
          end
        end else if (!load_above_release) begin
          state_nxt = OCPF_LOADMON;
          tmr_abort = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= OCPF_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  ocpf_delay_timer #(
    .CYCLES (DELAY_CYCLES),
    .CNT_W  (CNT_W)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tmr_start),
    .abort   (tmr_abort),
    .running (tmr_running),
    .done    (tmr_done)
  );

  // Control bits: writes land, release re-arms discharge unless dsg_changed_r is set, and wins over a same-cycle discharge bit write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
    end else begin
      if (wr_en && (paddr == ADDR_CTRL)) begin
        ctrl_r <= pwdata[CTRL_W-1:0];
      end
      if (ev_exit && !dsg_changed_r) begin
        ctrl_r[CTRL_DSG_BIT] <= 1'b1;
      end
    end
  end

  // Tracks a software change of the discharge bit during protection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsg_changed_r <= 1'b0;
    end else if (ev_enter) begin
      dsg_changed_r <= 1'b0;
    end else if (in_prot && wr_en && (paddr == ADDR_CTRL) &&
                 (pwdata[CTRL_DSG_BIT] != ctrl_r[CTRL_DSG_BIT])) begin
      dsg_changed_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RESET;
    end else if (wr_en && (paddr == ADDR_CONFIG)) begin
      cfg_r <= pwdata[CFG_W-1:0];
    end
  end

  // Gate pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsg_pin_r <= GATE_ON;
      chg_pin_r <= GATE_ON;
    end else if (ev_enter) begin
      dsg_pin_r <= GATE_OFF;
    end else if (prot_nxt) begin
      dsg_pin_r <= dsg_pin_r;
      chg_pin_r <= chg_pin_r;
    end else if (ev_exit && !dsg_changed_r) begin
      dsg_pin_r <= GATE_ON;
      chg_pin_r <= ctrl_r[CTRL_CHG_BIT] ? GATE_ON : GATE_OFF;
    end else begin
      dsg_pin_r <= ctrl_r[CTRL_DSG_BIT] ? GATE_ON : GATE_OFF;
      chg_pin_r <= ctrl_r[CTRL_CHG_BIT] ? GATE_ON : GATE_OFF;
    end
  end

  // Analog controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lmon_r   <= 1'b0;
      sel_hi_r <= CFG_RESET[CFG_SEL_HI_BIT];
      sel_lo_r <= CFG_RESET[CFG_SEL_LO_BIT];
      reg_en_r <= 1'b1;
    end else begin
      lmon_r   <= (state_nxt == OCPF_LOADMON);
      sel_hi_r <= cfg_r[CFG_SEL_HI_BIT];
      sel_lo_r <= cfg_r[CFG_SEL_LO_BIT];
      reg_en_r <= 1'b1;
    end
  end

  // Sticky interrupt status, set wins over write-one-to-clear
  assign ev_vec = IRQ_W'({ev_abort, ev_exit, ev_enter});
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= IRQ_RESET;
    end else if (wr_en && (paddr == ADDR_IRQ_STAT)) begin
      irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | ev_vec;
    end else begin
      irq_stat_r <= irq_stat_r | ev_vec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= IRQ_RESET;
    end else if (wr_en && (paddr == ADDR_IRQ_MASK)) begin
      irq_mask_r <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Read data selection
  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      ADDR_CTRL:     rd_mux[CTRL_W-1:0] = ctrl_r;
      ADDR_CONFIG:   rd_mux[CFG_W-1:0]  = cfg_r;
      ADDR_STATUS: begin
        rd_mux[STAT_PROT_BIT] = in_prot;
        rd_mux[STAT_LMON_BIT] = (state_r == OCPF_LOADMON);
        rd_mux[STAT_DET_BIT]  = (state_r == OCPF_DETECT);
        rd_mux[STAT_REL_BIT]  = (state_r == OCPF_RELEASE);
        rd_mux[STAT_CHG_BIT]  = dsg_changed_r;
      end
      ADDR_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_r;
      ADDR_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_r;
      default:       rd_mux = '0;
    endcase
  end

  // APB answer: one wait-free access cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= pwrite ? '0 : rd_mux;
      pready_r  <= 1'b1;
      pslverr_r <= !mapped;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata                       = prdata_r;
  assign pready                       = pready_r;
  assign pslverr                      = pslverr_r;
  assign discharge_gate_pin           = dsg_pin_r;
  assign charge_gate_load_monitor_pin = chg_pin_r;
  assign load_test_current_en         = lmon_r;
  assign oc_threshold_sel_hi          = sel_hi_r;
  assign oc_threshold_sel_lo          = sel_lo_r;
  assign regulator_en                 = reg_en_r;
  assign irq                          = irq_r;

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  detect_start_a: assert property (
    (state_r == OCPF_NORMAL) && sense_over_thresh |=> (state_r == OCPF_DETECT) && tmr_running)
    else $error("detection timer did not start");

  abandon_timer_a: assert property (
    (state_r == OCPF_DETECT) && !sense_over_thresh |=>
      (state_r == OCPF_NORMAL) && !tmr_running && (dsg_pin_r == $past(dsg_pin_r)))
    else $error("detection not abandoned cleanly");

  entry_cause_a: assert property (
    $rose(in_prot) |-> $past(tmr_done) && $past(sense_over_thresh) &&
      ($past(state_r) == OCPF_DETECT))
    else $error("protection entered without full delay");

  expiry_check_a: assert property (
    (state_r == OCPF_DETECT) && tmr_done && !sense_over_thresh |=> (state_r == OCPF_NORMAL))
    else $error("protection entered with sense low at expiry");

  gate_off_a: assert property (
    (state_r == OCPF_DETECT) && tmr_done && sense_over_thresh |=>
      (discharge_gate_pin == GATE_OFF) [*2])
    else $error("discharge gate not forced off");

  load_monitor_a: assert property (
    $rose(in_prot) |-> load_test_current_en ##1 (load_test_current_en || in_prot))
    else $error("load test current not started");

  release_cause_a: assert property (
    $fell(in_prot) |-> $past(tmr_done) && $past(load_above_release) &&
      ($past(state_r) == OCPF_RELEASE))
    else $error("protection left without release delay");

  auto_on_a: assert property (
    ev_exit && !dsg_changed_r |=> (discharge_gate_pin == GATE_ON) && ctrl_r[CTRL_DSG_BIT])
    else $error("discharge not restored on release");

  pins_hold_a: assert property (
    in_prot && $past(in_prot) |-> $stable(discharge_gate_pin) &&
      $stable(charge_gate_load_monitor_pin))
    else $error("gate pin moved during protection");

  threshold_sel_a: assert property (
    wr_en && (paddr == ADDR_CONFIG) |-> ##2
      ({oc_threshold_sel_hi, oc_threshold_sel_lo} == $past(pwdata[CFG_W-1:0], 2)))
    else $error("threshold select not applied");

  regulator_on_a: assert property (in_prot |-> regulator_en)
    else $error("regulator disabled in protection");

  normal_on_a: assert property (
    (state_r == OCPF_NORMAL) && $past(state_r == OCPF_NORMAL) &&
      $past(ctrl_r[CTRL_DSG_BIT]) && $past(ctrl_r[CTRL_DSG_BIT], 2) |->
      (discharge_gate_pin == GATE_ON))
    else $error("discharge off in normal operation");

  enter_c: cover property ($rose(in_prot));
  release_c: cover property ($fell(in_prot));
  abandon_c: cover property ((state_r == OCPF_DETECT) && !sense_over_thresh && !tmr_done);
  changed_c: cover property (ev_exit && dsg_changed_r);
endmodule

// [ocpf_delay_timer.sv]
// Down-counting delay timer shared by detection and release.
// Assumes start and abort are single-cycle requests in the pclk domain.
`timescale 1ns/1ns
module ocpf_delay_timer #(
  parameter int unsigned CYCLES = 100000,
  parameter int unsigned CNT_W  = 17
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic start,
  input  wire logic abort,
  // Status
  output logic      running,
  output logic      done
);

  logic [CNT_W-1:0] cnt_r;
  logic             running_r;
  logic             done_r;

  // One count serves both delays, as both come from the same capacitor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r     <= '0;
      running_r <= 1'b0;
    end else if (start) begin
      cnt_r     <= CNT_W'(CYCLES - 1);
      running_r <= 1'b1;
    end else if (abort) begin
      running_r <= 1'b0;
    end else if (running_r) begin
      if (cnt_r == '0) begin
        running_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else begin
      done_r <= running_r && (cnt_r == '0) && !start && !abort;
    end
  end

  assign running = running_r;
  assign done    = done_r;

endmodule

// [ocpf_load_model.sv]
// Far-side model: load and sense resistor, seen through the two comparators.
// Assumes the testbench sets the load current level and whether the short is gone.
`timescale 1ns/1ns
module ocpf_load_model
  import ocpf_pkg::*;
(
  // Device pins
  input  wire logic       discharge_gate_pin,
  input  wire logic       oc_threshold_sel_hi,
  input  wire logic       oc_threshold_sel_lo,
  // Load set by the testbench
  input  wire logic [2:0] load_lvl,
  input  wire logic       load_clear,
  // Comparator results
  output logic            sense_over_thresh,
  output logic            load_above_release
);
  logic [2:0] thr_idx;

  assign thr_idx = {1'b0, oc_threshold_sel_hi, oc_threshold_sel_lo} + 3'h1;
  // Current flows only while the discharge FET conducts
  assign sense_over_thresh  = (discharge_gate_pin == GATE_ON) && (load_lvl > thr_idx);
  assign load_above_release = load_clear;
endmodule

// [ocpf_pkg.sv]
// Package for the over-current protection controller: register map, fields, timing.
// Assumes a single 10 MHz APB clock and synchronous comparator inputs.
package ocpf_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_DSG_BIT = 0;
  localparam int unsigned CTRL_CHG_BIT = 1;
  localparam int unsigned CTRL_W       = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h3;

  // Configuration register fields
  localparam int unsigned CFG_SEL_LO_BIT = 0;
  localparam int unsigned CFG_SEL_HI_BIT = 1;
  localparam int unsigned CFG_W          = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 2'h0;

  // Status register fields
  localparam int unsigned STAT_PROT_BIT = 0;
  localparam int unsigned STAT_LMON_BIT = 1;
  localparam int unsigned STAT_DET_BIT  = 2;
  localparam int unsigned STAT_REL_BIT  = 3;
  localparam int unsigned STAT_CHG_BIT  = 4;

  // Interrupt status and mask fields
  localparam int unsigned IRQ_ENTER_BIT = 0;
  localparam int unsigned IRQ_EXIT_BIT  = 1;
  localparam int unsigned IRQ_ABORT_BIT = 2;
  localparam int unsigned IRQ_W         = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // Gate pin levels: high is the supply level, which turns the FET off
  localparam logic GATE_ON  = 1'b0;
  localparam logic GATE_OFF = 1'b1;

  // Detection and release delay, both set by the one timing capacitor
  localparam int unsigned CLK_FREQ_HZ  = 10_000_000;
  localparam int unsigned OC_DELAY_MS  = 10;
  localparam int unsigned OC_DELAY_CYC = OC_DELAY_MS * (CLK_FREQ_HZ / 1000);

  typedef enum logic [1:0] {
    OCPF_NORMAL  = 2'b00,
    OCPF_DETECT  = 2'b01,
    OCPF_LOADMON = 2'b10,
    OCPF_RELEASE = 2'b11
  } ocpf_state_t;

endpackage

// [test_overcurrent_protect_fsm.sv]
// Self-checking testbench for the over-current protection controller.
// Assumes ocpf_pkg, ocpf_ctrl and ocpf_load_model are compiled before it.
`timescale 1ns/1ns
module test_overcurrent_protect_fsm
  import ocpf_pkg::*;
;
  localparam int unsigned DLY = 8;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, sense_over_thresh, load_above_release;
  logic        discharge_gate_pin, charge_gate_load_monitor_pin, load_test_current_en;
  logic        oc_threshold_sel_hi, oc_threshold_sel_lo, regulator_en, irq;
  logic [2:0]  load_lvl = 3'h0;
  logic        load_clear = 1'b0;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          seed = 36579;

  always #50 pclk = ~pclk;

  ocpf_ctrl #(.DELAY_CYCLES(DLY)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sense_over_thresh, .load_above_release, .discharge_gate_pin,
    .charge_gate_load_monitor_pin, .load_test_current_en, .oc_threshold_sel_hi,
    .oc_threshold_sel_lo, .regulator_en, .irq
  );

  ocpf_load_model model (
    .discharge_gate_pin, .oc_threshold_sel_hi, .oc_threshold_sel_lo, .load_lvl,
    .load_clear, .sense_over_thresh, .load_above_release
  );

  task automatic conclude();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready as long as it takes, the watchdog bounds the run
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, wd, d, e);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    check(nm, d, exp);
  endtask

  task automatic drive(input logic [2:0] lvl, input logic clr);
    @(posedge pclk);
    load_lvl   <= lvl;
    load_clear <= clr;
  endtask

  task automatic wait_dsg(input logic v, output int cyc);
    cyc = 0;
    do begin
      @(negedge pclk);
      cyc++;
    end while (discharge_gate_pin !== v && cyc < 200);
  endtask

  function automatic logic [31:0] in_win(input int cyc);
    return 32'(cyc >= DLY + 1 && cyc <= DLY + 4);
  endfunction

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    conclude();
  end

  initial begin
    logic [31:0] d;
    logic        e;
    int          cyc;
    int          len;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("dsg_rst", 32'(discharge_gate_pin), 32'(GATE_ON));
    check("reg_rst", 32'(regulator_en), 32'h1);
    rdc("ctrl_rst", ADDR_CTRL, 32'(CTRL_RESET));
    rdc("mask_rst", ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, 8'h40, 32'hffff_ffff, d, e);
    check("unmap_err", 32'(e), 32'h1);
    apb(1'b0, 8'h40, 32'h0, d, e);
    check("unmap_rd", d, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CONFIG, 32'(s));
      repeat (2) @(negedge pclk);
      check("sel", 32'({oc_threshold_sel_hi, oc_threshold_sel_lo}), 32'(s));
      drive(3'(s + 1), 1'b0);
      repeat (2) @(negedge pclk);
      rdc("no_det", ADDR_STATUS, 32'h0);
      drive(3'(s + 2), 1'b0);
      repeat (2) @(negedge pclk);
      check("det_dsg", 32'(discharge_gate_pin), 32'(GATE_ON));
      rdc("det", ADDR_STATUS, 32'h1 << STAT_DET_BIT);
      drive(3'h0, 1'b0);
    end
    repeat (2) @(negedge pclk);
    check("irq_mask", 32'(irq), 32'h0);
    rdc("abort", ADDR_IRQ_STAT, 32'h1 << IRQ_ABORT_BIT);
    wr(ADDR_IRQ_MASK, 32'h7);
    repeat (2) @(negedge pclk);
    check("irq_on", 32'(irq), 32'h1);
    // Random short overloads never reach protection
    for (int i = 0; i < 12; i++) begin
      len = 1 + ($unsigned($random(seed)) % (DLY - 3));
      drive(3'($random(seed)), 1'b0);
      repeat (len) @(posedge pclk);
      drive(3'h0, 1'b0);
      repeat (3) @(negedge pclk);
      check("blip", 32'(discharge_gate_pin), 32'(GATE_ON));
    end
    // Overload gone just as the timer expires
    drive(3'h7, 1'b0);
    repeat (DLY) @(posedge pclk);
    drive(3'h0, 1'b0);
    repeat (4) @(negedge pclk);
    check("expiry_low", 32'(discharge_gate_pin), 32'(GATE_ON));
    wr(ADDR_IRQ_STAT, 32'h7);
    repeat (3) @(negedge pclk);
    check("irq_clr", 32'(irq), 32'h0);
    drive(3'h7, 1'b0);
    wait_dsg(GATE_OFF, cyc);
    check("t_det", in_win(cyc), 32'h1);
    check("lmon", 32'(load_test_current_en), 32'h1);
    check("reg_prot", 32'(regulator_en), 32'h1);
    rdc("enter", ADDR_IRQ_STAT, 32'h1 << IRQ_ENTER_BIT);
    wr(ADDR_CTRL, 32'h1);
    repeat (2) @(negedge pclk);
    check("chg_hold", 32'(charge_gate_load_monitor_pin), 32'(GATE_ON));
    check("dsg_hold", 32'(discharge_gate_pin), 32'(GATE_OFF));
    drive(3'h0, 1'b1);
    wait_dsg(GATE_ON, cyc);
    check("t_rel", in_win(cyc), 32'h1);
    rdc("ctrl_auto", ADDR_CTRL, 32'h1);
    rdc("exit_irq", ADDR_IRQ_STAT, (32'h1 << IRQ_ENTER_BIT) | (32'h1 << IRQ_EXIT_BIT));
    repeat (2) @(negedge pclk);
    check("chg_follow", 32'(charge_gate_load_monitor_pin), 32'(GATE_OFF));
    // Second episode: discharge bit flipped, release interrupted once
    wr(ADDR_CTRL, 32'h3);
    drive(3'h7, 1'b0);
    wait_dsg(GATE_OFF, cyc);
    check("t_det2", in_win(cyc), 32'h1);
    wr(ADDR_CTRL, 32'h2);
    drive(3'h0, 1'b1);
    repeat (3) @(posedge pclk);
    drive(3'h0, 1'b0);
    repeat (DLY + 4) @(negedge pclk);
    check("rel_abort", 32'(discharge_gate_pin), 32'(GATE_OFF));
    check("lmon_back", 32'(load_test_current_en), 32'h1);
    rdc("stat_lmon", ADDR_STATUS, (32'h1 << STAT_PROT_BIT) | (32'h1 << STAT_LMON_BIT) |
        (32'h1 << STAT_CHG_BIT));
    drive(3'h0, 1'b1);
    repeat (DLY + 6) @(negedge pclk);
    check("dsg_kept", 32'(discharge_gate_pin), 32'(GATE_OFF));
    apb(1'b0, ADDR_STATUS, 32'h0, d, e);
    check("prot_end", d & 32'h1, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    repeat (2) @(negedge pclk);
    check("dsg_on", 32'(discharge_gate_pin), 32'(GATE_ON));
    conclude();
  end
endmodule
